/* logic/cmam_pkg.sv */
/*
 * cmam_pkg: address map constants, region codes and reset values for the
 * program/data address decode block.
 * Assumes a single clock domain; every user of the map imports this package.
 */
`default_nettype none

package cmam_pkg;

    // --------------------------------------------------------------
    // program space
    // --------------------------------------------------------------
    localparam int PROG_AW = 24;
    localparam int PC_W = 23;
    localparam logic [PC_W-1:0] PC_RESET = 23'h000000;
    localparam logic [PC_W-1:0] PC_STEP = 23'h000002;
    localparam logic [PROG_AW-1:0] USER_TOP = 24'h7FFFFF;
    localparam logic [PROG_AW-1:0] CODE_START_LOC = 24'h000002;
    localparam logic [PROG_AW-1:0] VEC_END = 24'h000200;
    localparam logic [PROG_AW-1:0] IVT_PRI_LO = 24'h000004;
    localparam logic [PROG_AW-1:0] IVT_PRI_HI = 24'h0000FF;
    localparam logic [PROG_AW-1:0] IVT_ALT_LO = 24'h000104;
    localparam logic [PROG_AW-1:0] IVT_ALT_HI = 24'h0001FF;
    localparam logic [PROG_AW-1:0] EE_BASE = 24'h7FFE00;
    localparam int EE_WORDS = 256;
    localparam logic [PROG_AW-1:0] CFG_BASE = 24'hF80000;
    localparam logic [PROG_AW-1:0] CFG_GAP = 24'hF80002;
    localparam logic [PROG_AW-1:0] CFG_LAST = 24'hF80010;
    localparam int TBL_CFG_BIT = 7;

    // --------------------------------------------------------------
    // data space
    // --------------------------------------------------------------
    localparam int DATA_AW = 16;
    localparam int NEAR_W = 13;
    localparam int DRAM_WORDS = 1024;
    localparam logic [DATA_AW-1:0] WREG_TOP = 16'h001E;
    localparam logic [DATA_AW-1:0] TPAGE_ADDR = 16'h0032;
    localparam logic [DATA_AW-1:0] CTRL_ADDR = 16'h0044;
    localparam logic [DATA_AW-1:0] SFR_TOP = 16'h07FF;
    localparam logic [DATA_AW-1:0] DRAM_BASE = 16'h0800;
    localparam logic [DATA_AW-1:0] DRAM_TOP = 16'h0FFF;
    localparam logic [DATA_AW-1:0] NEAR_TOP = 16'h1FFF;
    localparam int VIS_BIT = 2;
    localparam logic [15:0] WREG_RESET = 16'h0000;
    localparam logic [7:0] TPAGE_RESET = 8'h00;

    // data space regions seen by both address generators
    typedef enum logic [2:0] {
        CMAM_REG_WREG = 3'b000,
        CMAM_REG_TPAGE = 3'b001,
        CMAM_REG_CTRL = 3'b010,
        CMAM_REG_SFR = 3'b011,
        CMAM_REG_DRAM = 3'b100,
        CMAM_REG_VIS = 3'b101,
        CMAM_REG_NONE = 3'b110
    } cmam_region_t;

endpackage

`default_nettype wire

/* logic/cmam_dram.sv */
/*
 * cmam_dram: data memory as two byte-wide halves with a shared word index
 * and separate write strobes. Read is combinational from the flop array.
 * Assumes the caller registers the read result and gates misaligned stores.
 */
`timescale 1ns/1ps
`default_nettype none

module cmam_dram
    import cmam_pkg::*;
#(
    parameter int DEPTH = DRAM_WORDS,
    parameter int IW = 10
) (
    input wire logic clock_i,
    input wire logic [IW-1:0] rd_index_i,
    input wire logic [IW-1:0] wr_index_i,
    input wire logic wr_lo_i,
    input wire logic wr_hi_i,
    input wire logic [15:0] wr_data_i,
    output logic [15:0] rd_word_o
);

    logic [7:0] mem_lo [DEPTH];
    logic [7:0] mem_hi [DEPTH];

    // --------------------------------------------------------------
    // storage
    // --------------------------------------------------------------
    // each half has its own strobe so byte stores leave the other half
    always_ff @(posedge clock_i) begin
        if (wr_lo_i) begin
            mem_lo[wr_index_i] <= wr_data_i[7:0]; // R14
        end
        if (wr_hi_i) begin
            mem_hi[wr_index_i] <= wr_data_i[15:8]; // R14
        end
    end

    // shared word decode feeds both halves
    assign rd_word_o = {mem_hi[rd_index_i], mem_lo[rd_index_i]};

endmodule

`default_nettype wire

/* logic/cmam_top.sv */
/*
 * cmam_top: program address formation and data space decode for a 16-bit
 * core: counter, table and visibility windows, byte lanes, traps, W array.
 * Assumes the program memory answers prog_rdata_i combinationally for the
 * word at prog_addr_o, and the core issues at most one access per generator per cycle.
 */
`timescale 1ns/1ps
`default_nettype none

// What this block does
// R1: program addresses are 24 bits, from 23-bit counter, table ops or window.
// R2: fetch and window stay below 800000h; table page bit 7 opens config space.
// R3: even address gives lower word, odd gives upper word with zero top byte.
// R4: counter stays word aligned and steps by two either way.
// R5: vectors below 000200h; reset starts at 000000h, code start at 000002h.
// R6: primary vector table 000004h-0000FFh, alternate 000104h-0001FFh.
// R7: data EEPROM of 256 words at 7FFE00 reached by table ops.
// R8: eight config words at even F80000-F80010, F80002 unused.
// R9: data addresses are 16-bit byte addresses over 64 Kbytes.
// R10: top address bit clear means memory, set means program window.
// R11: 1024 data words; reads outside implemented locations return zero.
// R12: separate read and write address generators.
// R13: byte read fetches word, lsb picks byte, placed on low lane.
// R14: shared word decode, separate byte strobes, byte write hits one half.
// R15: post-increment adds one for bytes, two for words.
// R16: odd word access traps; misaligned write store suppressed.
// R17: byte load to a working register leaves its high byte.
// R18: sign-extend widens low byte, zero-extend clears high byte.
// R19: 0000h-1FFFh reachable through 13-bit direct field.
// R20: move instructions reach all data space with 16-bit field.
// R21: all data memory lies inside the near region.
// R22: control register visibility bit gates the program window.
// R23: 0000h-07FFh are special registers; unused ones read zero.
// R24: address error is a one-cycle pulse.
module cmam_top
    import cmam_pkg::*;
(
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic pc_advance_i,
    input wire logic pc_backward_i,
    input wire logic pc_load_i,
    input wire logic [PC_W-1:0] pc_target_i,
    input wire logic table_read_op_i,
    input wire logic table_write_op_i,
    input wire logic [15:0] table_offset_i,
    input wire logic [8:0] vis_page_i,
    input wire logic [PROG_AW-1:0] prog_rdata_i,
    input wire logic rd_req_i,
    input wire logic rd_byte_i,
    input wire logic rd_near_i,
    input wire logic [DATA_AW-1:0] rd_ea_i,
    input wire logic wr_req_i,
    input wire logic wr_byte_i,
    input wire logic wr_near_i,
    input wire logic [DATA_AW-1:0] wr_ea_i,
    input wire logic [15:0] wr_data_i,
    input wire logic wreg_load_i,
    input wire logic wreg_byte_i,
    input wire logic sign_extend_op_i,
    input wire logic zero_extend_op_i,
    input wire logic [3:0] wreg_sel_i,
    input wire logic [15:0] wreg_data_i,
    output logic [PC_W-1:0] program_counter_o,
    output logic [PROG_AW-1:0] prog_addr_o,
    output logic prog_write_o,
    output logic [15:0] prog_data_o,
    output logic vector_hit_o,
    output logic ivt_primary_o,
    output logic ivt_alternate_o,
    output logic eeprom_sel_o,
    output logic [7:0] eeprom_index_o,
    output logic config_sel_o,
    output logic [3:0] config_index_o,
    output logic rd_valid_o,
    output logic [15:0] rd_data_o,
    output logic [DATA_AW-1:0] rd_ptr_next_o,
    output logic [DATA_AW-1:0] wr_ptr_next_o,
    output logic addr_error_o,
    output logic [15:0] wreg_rd_o,
    output logic [7:0] table_page_register_o,
    output logic vis_enable_o
);

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    function automatic logic [DATA_AW-1:0] form_ea(input logic [DATA_AW-1:0] raw, input logic near);
        form_ea = near ? {{(DATA_AW-NEAR_W){1'b0}}, raw[NEAR_W-1:0]} : raw;
    endfunction

    function automatic cmam_region_t decode(input logic [DATA_AW-1:0] ea);
        if (ea[DATA_AW-1]) begin
            decode = CMAM_REG_VIS;
        end else if (ea <= WREG_TOP) begin
            decode = CMAM_REG_WREG;
        end else if (ea[15:1] == TPAGE_ADDR[15:1]) begin
            decode = CMAM_REG_TPAGE;
        end else if (ea[15:1] == CTRL_ADDR[15:1]) begin
            decode = CMAM_REG_CTRL;
        end else if (ea <= SFR_TOP) begin
            decode = CMAM_REG_SFR;
        end else if (ea <= DRAM_TOP) begin
            decode = CMAM_REG_DRAM;
        end else begin
            decode = CMAM_REG_NONE;
        end
    endfunction

    function automatic logic [15:0] lane(input logic [15:0] w, input logic odd, input logic byte_op);
        lane = byte_op ? {8'h00, (odd ? w[15:8] : w[7:0])} : w;
    endfunction

    function automatic logic [DATA_AW-1:0] postinc(input logic [DATA_AW-1:0] ea, input logic byte_op);
        postinc = ea + (byte_op ? 16'h0001 : 16'h0002);
    endfunction

    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    logic [15:0] wreg [16];
    logic [7:0] tpage;
    logic vis_en;
    logic vis_pend;
    logic vis_odd;
    logic vis_byte;

    // --------------------------------------------------------------
    // data side decode, one path per address generator
    // --------------------------------------------------------------
    logic [DATA_AW-1:0] rea;
    logic [DATA_AW-1:0] wea;
    cmam_region_t rreg;
    cmam_region_t wregion;
    logic rd_mis;
    logic wr_mis;
    logic rd_vis;
    logic wr_ok;
    logic [15:0] dram_word;
    logic [15:0] rd_word;
    logic [15:0] wr_lane_data;
    logic wr_lo;
    logic wr_hi;
    logic wr_dram_lo;
    logic wr_dram_hi;

    // independent read and write address generators
    assign rea = form_ea(rd_ea_i, rd_near_i); // R12 R19 R20
    assign wea = form_ea(wr_ea_i, wr_near_i); // R12 R19 R20
    assign rreg = decode(rea); // R9 R10
    assign wregion = decode(wea); // R10
    assign rd_mis = rd_req_i && !rd_byte_i && rea[0]; // R16
    assign wr_mis = wr_req_i && !wr_byte_i && wea[0]; // R16
    // window read only when the control bit allows it
    assign rd_vis = rd_req_i && (rreg == CMAM_REG_VIS) && vis_en; // R22
    // a misaligned word store is dropped, the instruction still retires
    assign wr_ok = wr_req_i && !wr_mis; // R16
    assign wr_lo = wr_ok && (!wr_byte_i || !wea[0]); // R14
    assign wr_hi = wr_ok && (!wr_byte_i || wea[0]); // R14
    assign wr_lane_data = wr_byte_i ? {wr_data_i[7:0], wr_data_i[7:0]} : wr_data_i;
    assign wr_dram_lo = wr_lo && (wregion == CMAM_REG_DRAM);
    assign wr_dram_hi = wr_hi && (wregion == CMAM_REG_DRAM);

    // word selection; anything unimplemented reads as zero
    assign rd_word = (rreg == CMAM_REG_WREG) ? wreg[rea[4:1]] :
                     (rreg == CMAM_REG_TPAGE) ? {8'h00, tpage} :
                     (rreg == CMAM_REG_CTRL) ? {13'h0000, vis_en, 2'b00} :
                     (rreg == CMAM_REG_DRAM) ? dram_word : 16'h0000; // R11 R23

    // data memory sits at 0800h-0FFFh, inside the near region
    cmam_dram #(
        .DEPTH(DRAM_WORDS),
        .IW(10)
    ) u_dram (
        .clock_i(clock_i),
        .rd_index_i(rea[10:1]),
        .wr_index_i(wea[10:1]),
        .wr_lo_i(wr_dram_lo),
        .wr_hi_i(wr_dram_hi),
        .wr_data_i(wr_lane_data),
        .rd_word_o(dram_word)
    ); // R11 R21

    // --------------------------------------------------------------
    // program side address formation
    // --------------------------------------------------------------
    logic [PC_W-1:0] next_pc;
    logic [PROG_AW-1:0] next_prog_addr;
    logic table_op;
    logic ee_hit;
    logic cfg_hit;
    logic [PROG_AW-1:0] cfg_off;

    assign table_op = table_read_op_i || table_write_op_i;
    // load is forced even; sequential steps keep it even
    assign next_pc = pc_load_i ? {pc_target_i[PC_W-1:1], 1'b0} :
                     pc_advance_i ? program_counter_o + PC_STEP :
                     pc_backward_i ? program_counter_o - PC_STEP : program_counter_o; // R4
    // window read first, then table ops, else the counter; fetch and window
    // addresses carry bit 23 clear, only a table op with page bit 7 gets above
    assign next_prog_addr = rd_vis ? {1'b0, vis_page_i[7:0], rea[14:0]} :
                            table_op ? {tpage, table_offset_i} :
                            {1'b0, program_counter_o}; // R1 R2
    assign ee_hit = (next_prog_addr >= EE_BASE) && (next_prog_addr <= USER_TOP);
    assign cfg_off = next_prog_addr - CFG_BASE;
    assign cfg_hit = (next_prog_addr >= CFG_BASE) && (next_prog_addr <= CFG_LAST) &&
                     !next_prog_addr[0] && (next_prog_addr != CFG_GAP); // R8

    // counter and program address registers
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            program_counter_o <= PC_RESET; // R5
            prog_addr_o <= {1'b0, PC_RESET};
            prog_write_o <= 1'b0;
        end else begin
            program_counter_o <= next_pc;
            prog_addr_o <= next_prog_addr;
            prog_write_o <= table_write_op_i && !rd_vis;
        end
    end

    // region flags for the program memory and config logic
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            vector_hit_o <= 1'b1;
            ivt_primary_o <= 1'b0;
            ivt_alternate_o <= 1'b0;
            eeprom_sel_o <= 1'b0;
            eeprom_index_o <= 8'h00;
            config_sel_o <= 1'b0;
            config_index_o <= 4'h0;
        end else begin
            vector_hit_o <= next_prog_addr < VEC_END; // R5
            ivt_primary_o <= (next_prog_addr >= IVT_PRI_LO) && (next_prog_addr <= IVT_PRI_HI); // R6
            ivt_alternate_o <= (next_prog_addr >= IVT_ALT_LO) && (next_prog_addr <= IVT_ALT_HI); // R6
            eeprom_sel_o <= table_op && !rd_vis && ee_hit; // R7
            eeprom_index_o <= next_prog_addr[8:1]; // R7
            config_sel_o <= table_op && !rd_vis && cfg_hit && tpage[TBL_CFG_BIT]; // R2 R8
            config_index_o <= cfg_off[4:1];
        end
    end

    // upper word shows the high byte only, top byte is a phantom zero
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            prog_data_o <= 16'h0000;
        end else begin
            prog_data_o <= prog_addr_o[0] ? {8'h00, prog_rdata_i[23:16]} : prog_rdata_i[15:0]; // R3
        end
    end

    // --------------------------------------------------------------
    // read answer and pointer updates
    // --------------------------------------------------------------
    // a window read needs one extra cycle for the program memory; a request
    // arriving in that cycle is dropped, which the core must avoid
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            rd_valid_o <= 1'b0;
            rd_data_o <= 16'h0000;
            vis_pend <= 1'b0;
            vis_odd <= 1'b0;
            vis_byte <= 1'b0;
        end else begin
            vis_pend <= rd_vis && !vis_pend;
            vis_odd <= rea[0];
            vis_byte <= rd_byte_i;
            rd_valid_o <= vis_pend || (rd_req_i && !rd_vis);
            if (vis_pend) begin
                rd_data_o <= lane(prog_rdata_i[15:0], vis_odd, vis_byte); // R13
            end else if (rd_req_i && !rd_vis) begin
                rd_data_o <= lane(rd_word, rea[0], rd_byte_i); // R13 R11
            end
        end
    end

    // pointer post-increment scaled by operand size
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            rd_ptr_next_o <= 16'h0000;
            wr_ptr_next_o <= 16'h0000;
            addr_error_o <= 1'b0;
        end else begin
            rd_ptr_next_o <= rd_req_i ? postinc(rea, rd_byte_i) : rd_ptr_next_o; // R15
            wr_ptr_next_o <= wr_req_i ? postinc(wea, wr_byte_i) : wr_ptr_next_o; // R15
            addr_error_o <= rd_mis || wr_mis; // R16 R24
        end
    end

    // --------------------------------------------------------------
    // special registers and working registers
    // --------------------------------------------------------------
    logic wr_tpage;
    logic wr_ctrl;
    logic [15:0] wreg_cur;
    logic [15:0] wreg_port_next;

    assign wr_tpage = wr_lo && (wregion == CMAM_REG_TPAGE);
    assign wr_ctrl = wr_lo && (wregion == CMAM_REG_CTRL);
    assign wreg_cur = wreg[wreg_sel_i];
    // extend ops act on the register itself; a byte load keeps the high half
    assign wreg_port_next = sign_extend_op_i ? {{8{wreg_cur[7]}}, wreg_cur[7:0]} :
                            zero_extend_op_i ? {8'h00, wreg_cur[7:0]} :
                            wreg_byte_i ? {wreg_cur[15:8], wreg_data_i[7:0]} : wreg_data_i; // R17 R18

    // control bits live in the low lane of their words
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            tpage <= TPAGE_RESET;
            vis_en <= 1'b0;
        end else begin
            tpage <= wr_tpage ? wr_lane_data[7:0] : tpage;
            vis_en <= wr_ctrl ? wr_lane_data[VIS_BIT] : vis_en; // R22
        end
    end

    // core port wins over a data space store to the same register
    always_ff @(posedge clock_i) begin
        for (int i = 0; i < 16; i++) begin
            if (sys_rst_i) begin
                wreg[i] <= WREG_RESET;
            end else if ((wreg_load_i || sign_extend_op_i || zero_extend_op_i) && wreg_sel_i == 4'(i)) begin
                wreg[i] <= wreg_port_next; // R17 R18
            end else if (wregion == CMAM_REG_WREG && wea[4:1] == 4'(i)) begin
                if (wr_lo) begin
                    wreg[i][7:0] <= wr_lane_data[7:0]; // R14
                end
                if (wr_hi) begin
                    wreg[i][15:8] <= wr_lane_data[15:8]; // R14
                end
            end
        end
    end

    // register mirrors for the core
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            wreg_rd_o <= WREG_RESET;
            table_page_register_o <= TPAGE_RESET;
            vis_enable_o <= 1'b0;
        end else begin
            wreg_rd_o <= wreg_cur;
            table_page_register_o <= tpage;
            vis_enable_o <= vis_en;
        end
    end

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_vis_req;
        rd_vis && !vis_pend;
    endsequence
    sequence s_vis_wait;
        vis_pend && !rd_valid_o;
    endsequence

    property p_pc_step;
        pc_advance_i && !pc_load_i |=> program_counter_o == $past(program_counter_o) + PC_STEP;
    endproperty
    a_pc_step: assert property (p_pc_step) else $error("counter did not advance by two"); // R4
    property p_pc_even;
        program_counter_o[0] == 1'b0;
    endproperty
    a_pc_even: assert property (p_pc_even) else $error("counter lost word alignment"); // R4
    property p_fetch_user;
        !$past(table_op) |-> prog_addr_o[PROG_AW-1] == 1'b0;
    endproperty
    a_fetch_user: assert property (p_fetch_user) else $error("non table access above user space"); // R2
    property p_phantom;
        $past(prog_addr_o[0]) |-> prog_data_o[15:8] == 8'h00;
    endproperty
    a_phantom: assert property (p_phantom) else $error("upper word top byte not zero"); // R3
    property p_trap;
        (rd_mis || wr_mis) |=> addr_error_o ##1 (addr_error_o == $past(rd_mis || wr_mis));
    endproperty
    a_trap: assert property (p_trap) else $error("misaligned access gave no error pulse"); // R16 R24
    property p_no_store;
        wr_mis |-> !wr_dram_lo && !wr_dram_hi && !wr_tpage && !wr_ctrl;
    endproperty
    a_no_store: assert property (p_no_store) else $error("misaligned store reached memory"); // R16
    property p_byte_lane;
        rd_req_i && rd_byte_i && !rd_vis && !vis_pend |=> rd_valid_o && rd_data_o[15:8] == 8'h00;
    endproperty
    a_byte_lane: assert property (p_byte_lane) else $error("byte read high lane not clear"); // R13
    property p_postinc;
        rd_req_i |=> rd_ptr_next_o == $past(rea) + ($past(rd_byte_i) ? 16'h0001 : 16'h0002);
    endproperty
    a_postinc: assert property (p_postinc) else $error("pointer step wrong for size"); // R15
    property p_byte_load;
        wreg_load_i && wreg_byte_i && !sign_extend_op_i && !zero_extend_op_i
            |=> wreg[$past(wreg_sel_i)][15:8] == $past(wreg_cur[15:8]);
    endproperty
    a_byte_load: assert property (p_byte_load) else $error("byte load changed high byte"); // R17
    property p_vis_answer;
        s_vis_req |=> s_vis_wait ##1 rd_valid_o;
    endproperty
    a_vis_answer: assert property (p_vis_answer) else $error("window read not answered in two cycles"); // R22
    property p_out_zero;
        rd_req_i && !rd_vis && !vis_pend && (rreg == CMAM_REG_NONE || rreg == CMAM_REG_SFR)
            |=> rd_data_o == 16'h0000;
    endproperty
    a_out_zero: assert property (p_out_zero) else $error("unimplemented address read nonzero"); // R11

endmodule

`default_nettype wire

/* verification/cmam_prog_model.sv */
/*
 * cmam_prog_model: program memory seen by the address block.
 * Assumes a combinational answer for the word at addr_i.
 */
`timescale 1ns/1ps
`default_nettype none

module cmam_prog_model
    import cmam_pkg::*;
(
    input wire logic [PROG_AW-1:0] addr_i,
    output logic [PROG_AW-1:0] rdata_o
);
    // pattern per location, so a wrong word or byte lane shows up
    assign rdata_o = {addr_i[23:16] ^ 8'hC3, addr_i[15:0] ^ 16'h1234};
endmodule

`default_nettype wire

/* verification/cpu_memory_address_map_bench.sv */
/*
 * bench for cmam_top: drives core side, queues expected reads.
 * Assumes cmam_prog_model answers program reads.
 */
`timescale 1ns/1ps
`default_nettype none

module cpu_memory_address_map_bench;
    import cmam_pkg::*;
    // ----------------------------------------
    // signals and instances
    // ----------------------------------------
    logic clock_i = 1'b0, sys_rst_i = 1'b1, rd_valid_o, addr_error_o, vis_enable_o, vector_hit_o;
    logic pc_advance_i, pc_backward_i, pc_load_i, table_read_op_i, rd_req_i, rd_byte_i, wr_req_i, wr_byte_i;
    logic wreg_load_i, wreg_byte_i, sign_extend_op_i, zero_extend_op_i, eeprom_sel_o, config_sel_o, rd_near_i;
    logic [3:0] wreg_sel_i, config_index_o;
    logic [7:0] eeprom_index_o, table_page_register_o;
    logic [8:0] vis_page_i;
    logic [15:0] table_offset_i, rd_ea_i, wr_ea_i, wr_data_i, wreg_data_i, prog_data_o, rd_data_o, d;
    logic [15:0] wr_ptr_next_o, wreg_rd_o;
    logic [22:0] pc_target_i, program_counter_o;
    logic [23:0] prog_rdata_i, prog_addr_o;
    logic [15:0] exp_q[$];
    int err_count = 0, n_tests = 0, n_aerr = 0, cycles = 0;

    cmam_top i_dut (.clock_i, .sys_rst_i, .pc_advance_i, .pc_backward_i, .pc_load_i, .pc_target_i,
        .table_read_op_i, .table_write_op_i(1'b0), .table_offset_i, .vis_page_i, .prog_rdata_i, .rd_req_i,
        .rd_byte_i, .rd_near_i, .rd_ea_i, .wr_req_i, .wr_byte_i, .wr_near_i(1'b0), .wr_ea_i, .wr_data_i,
        .wreg_load_i, .wreg_byte_i, .sign_extend_op_i, .zero_extend_op_i, .wreg_sel_i, .wreg_data_i,
        .program_counter_o, .prog_addr_o, .prog_write_o(), .prog_data_o, .vector_hit_o, .ivt_primary_o(),
        .ivt_alternate_o(), .eeprom_sel_o, .eeprom_index_o, .config_sel_o, .config_index_o, .rd_valid_o,
        .rd_data_o, .rd_ptr_next_o(), .wr_ptr_next_o, .addr_error_o, .wreg_rd_o, .table_page_register_o,
        .vis_enable_o);
    cmam_prog_model i_mem (.addr_i(prog_addr_o), .rdata_o(prog_rdata_i));

    always #2.5 clock_i = ~clock_i;

    task automatic finish_test;
        if (err_count == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // wr, rd and wop are entered at a falling edge; wr and rd leave their strobe up, wop clears its op strobes
    task automatic wr(input logic [15:0] ea, input logic b, input logic [15:0] dat);
        wr_req_i = 1'b1;
        wr_byte_i = b;
        wr_ea_i = ea;
        wr_data_i = dat;
        @(negedge clock_i);
        chk("wr_ptr", 24'(ea + (b ? 16'h0001 : 16'h0002)), 24'(wr_ptr_next_o));
    endtask

    task automatic rd(input logic [15:0] ea, input logic b, input logic [15:0] exp);
        rd_req_i = 1'b1;
        rd_byte_i = b;
        rd_ea_i = ea;
        exp_q.push_back(exp);
        @(negedge clock_i);
    endtask

    task automatic wop(input logic [3:0] op, input logic [15:0] dat, input logic [15:0] exp);
        {wreg_load_i, wreg_byte_i, sign_extend_op_i, zero_extend_op_i} = op;
        wreg_data_i = dat;
        @(negedge clock_i);
        {wreg_load_i, wreg_byte_i, sign_extend_op_i, zero_extend_op_i} = 4'h0;
        repeat (2) @(negedge clock_i);
        chk("wreg", 24'(exp), 24'(wreg_rd_o));
    endtask

    // answers are matched oldest first, whatever their latency
    always @(negedge clock_i) begin
        if (rd_valid_o === 1'b1) begin
            chk("rd_data", exp_q.size() > 0 ? 24'(exp_q.pop_front()) : 24'hFFFFFF, 24'(rd_data_o));
        end
        if (addr_error_o === 1'b1) begin
            n_aerr++;
        end
    end

    // hang guard, well above the fifty or so cycles used
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            finish_test();
        end
    end

    initial begin
        {pc_advance_i, pc_backward_i, pc_load_i, table_read_op_i, rd_req_i, rd_byte_i, wr_req_i, wr_byte_i} = '0;
        {wreg_load_i, wreg_byte_i, sign_extend_op_i, zero_extend_op_i, vis_page_i, pc_target_i} = '0;
        {table_offset_i, rd_ea_i, wr_ea_i, wr_data_i, wreg_data_i, rd_near_i} = '0;
        wreg_sel_i = 4'h3;
        void'($urandom(32'h4497));
        d = 16'($urandom);
        repeat (8) @(negedge clock_i);
        chk("pc", 24'h000000, 24'(program_counter_o));
        chk("vec", 24'h000001, 24'(vector_hit_o));
        sys_rst_i = 1'b0;
        @(negedge clock_i);
        pc_advance_i = 1'b1;
        repeat (3) @(negedge clock_i);
        {pc_advance_i, pc_backward_i} = 2'b01;
        @(negedge clock_i);
        {pc_backward_i, pc_load_i, pc_target_i} = {2'b01, 23'h000201};
        chk("pc", 24'h000004, 24'(program_counter_o));
        @(negedge clock_i);
        pc_load_i = 1'b0;
        @(negedge clock_i);
        chk("paddr", 24'h000200, prog_addr_o);
        chk("vec", 24'h000000, 24'(vector_hit_o));
        wr(16'h0800, 1'b0, d);
        wr(16'h0801, 1'b1, 16'h00AB);
        wr(16'h0802, 1'b0, 16'h5A5A);
        wr(16'h0803, 1'b0, 16'hFFFF);
        wr(TPAGE_ADDR, 1'b0, 16'h00F8);
        wr_req_i = 1'b0;
        rd(16'h0800, 1'b0, {8'hAB, d[7:0]});
        rd_near_i = 1'b1;
        rd(16'hE800, 1'b0, {8'hAB, d[7:0]});
        rd_near_i = 1'b0;
        rd(16'h0801, 1'b1, 16'h00AB);
        rd(16'h0800, 1'b1, {8'h00, d[7:0]});
        rd(16'h0803, 1'b0, 16'h5A5A);
        rd(16'h1000, 1'b0, 16'h0000);
        rd(16'h0040, 1'b0, 16'h0000);
        rd(16'h8000, 1'b0, 16'h0000);
        rd_req_i = 1'b0;
        wr(CTRL_ADDR, 1'b0, 16'h0004);
        wr_req_i = 1'b0;
        vis_page_i = 9'h001;
        @(negedge clock_i);
        chk("vis", 24'h000001, 24'(vis_enable_o));
        chk("tpage", 24'h0000F8, 24'(table_page_register_o));
        rd(16'h8006, 1'b0, 16'h9232);
        rd_req_i = 1'b0;
        {table_read_op_i, table_offset_i} = {1'b1, 16'h0004};
        repeat (2) @(negedge clock_i);
        table_offset_i = 16'h0005;
        chk("paddr", 24'hF80004, prog_addr_o);
        chk("cfg", 24'h000012, 24'({config_sel_o, config_index_o}));
        @(negedge clock_i);
        chk("pdata", 24'h001230, 24'(prog_data_o));
        wr(TPAGE_ADDR, 1'b0, 16'h007F);
        {wr_req_i, table_offset_i} = {1'b0, 16'hFE06};
        chk("pdata", 24'h00003B, 24'(prog_data_o));
        @(negedge clock_i);
        chk("ee", 24'h000103, 24'({eeprom_sel_o, eeprom_index_o}));
        table_read_op_i = 1'b0;
        wop(4'h8, d, d);
        wop(4'hC, 16'h56AB, {d[15:8], 8'hAB});
        wop(4'h2, 16'h0000, 16'hFFAB);
        wop(4'h1, 16'h0000, 16'h00AB);
        chk("pending", 24'h000000, 24'(exp_q.size()));
        chk("aerr", 24'h000002, 24'(n_aerr));
        finish_test();
    end
endmodule

`default_nettype wire
